// ==== shared/pco_consts.svh ====
// Purpose: Offsets, fields, reset values and codes of the clock output control
// Assumes: Register offsets are word indices; byte address is four times the index
// Notes:   Definitions only
`ifndef PCO_CONSTS_SVH
`define PCO_CONSTS_SVH
`define PCO_CTRL_INDEX      8'h3d
`define PCO_RATIO_INDEX     8'h3e
`define PCO_CTRL_ADDR       {22'h000000, `PCO_CTRL_INDEX, 2'h0}
`define PCO_RATIO_ADDR      {22'h000000, `PCO_RATIO_INDEX, 2'h0}
`define PCO_CTRL_RESET      8'h04
`define PCO_RATIO_RESET     8'h08
`define PCO_SEL_MSB         7
`define PCO_SEL_LSB         4
`define PCO_EN_BIT          3
`define PCO_PD_BIT          2
`define PCO_FB_MSB          1
`define PCO_FB_LSB          0
`define PCO_FB_CODE_27      2'h1
`define PCO_FB_CODE_28      2'h2
`define PCO_FB_MUL_23       5'h17
`define PCO_FB_MUL_27       5'h1b
`define PCO_FB_MUL_28       5'h1c
`define PCO_SEL_GPIO        4'h0
`define PCO_SEL_PLL         4'h1
`define PCO_SEL_LOW         4'h2
`define PCO_SEL_HIGH        4'h3
`define PCO_SEL_XTAL        4'h4
`define PCO_SEL_XTAL_DIV2   4'h5
`define PCO_SEL_XTAL_DIV4   4'h6
`define PCO_SEL_XTAL_DIV8   4'h7
`define PCO_SEL_TIMER_FIRST 4'h8
`define PCO_SEL_TIMER_LAST  4'hb
`endif

// ==== shared/pco_pkg.sv ====
// Purpose: Types shared by the clock output control modules
// Assumes: Nothing
// Notes:   Constants live in pco_consts.svh
package pco_pkg;
	typedef logic [7:0] pco_byte_type;
	typedef logic [3:0] pco_select_type;
endpackage

// ==== shared/pco_reg_if.sv ====
// Purpose: Register write strobes and readback between bus slave and core
// Assumes: One clock domain
// Notes:   Strobes are one-cycle pulses in the bus data phase
`timescale 1ns/1ps
interface pco_reg_if;
	logic                 wr_ctrl;
	logic                 wr_ratio;
	pco_pkg::pco_byte_type wdata;
	pco_pkg::pco_byte_type ctrl_value;
	pco_pkg::pco_byte_type ratio_value;
	modport bus (output wr_ctrl, output wr_ratio, output wdata, input ctrl_value, input ratio_value);
	modport core (input wr_ctrl, input wr_ratio, input wdata, output ctrl_value, output ratio_value);
endinterface

// ==== rtl/pco_ratio_div.sv ====
// Purpose: Divides a stream of tick pulses by a programmable ratio
// Assumes: Ratio of at least 2 for a toggling output
// Notes:   Output is high for the first half of each period
`timescale 1ns/1ps
module pco_ratio_div #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] ratio,
	output logic                  div_out
);
	if (WIDTH < 2) begin : g_width_check
		$error("pco_ratio_div needs WIDTH of at least 2");
	end

	logic [WIDTH-1:0] count;
	wire  [WIDTH-1:0] last_count = ratio - WIDTH'(1);
	wire  [WIDTH-1:0] half_ratio = ratio >> 1;
	wire  [WIDTH-1:0] next_count = (count >= last_count) ? '0 : count + WIDTH'(1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count   <= '0;
			div_out <= 1'b0;
		end else if (clear) begin
			count   <= '0;
			div_out <= 1'b0;
		end else if (tick) begin
			count   <= next_count;
			div_out <= next_count < half_ratio;
		end
	end
endmodule

// ==== rtl/pco_ahb_slave.sv ====
// Purpose: AHB-Lite slave for the two control registers
// Assumes: Single word transfers; no wait states
// Notes:   Unmapped reads return zero, unmapped writes are dropped, always OKAY
`timescale 1ns/1ps
`include "pco_consts.svh"
module pco_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	pco_reg_if.bus           regs
);
	logic        wr_pending;
	logic [31:0] wr_addr;

	wire take      = hsel & hready & htrans[1];
	wire hit_ctrl  = haddr == `PCO_CTRL_ADDR;
	wire hit_ratio = haddr == `PCO_RATIO_ADDR;
	// Forward a write still in its data phase so a back-to-back read is not stale
	wire fwd       = wr_pending & (wr_addr == haddr);
	wire [7:0] ctrl_now  = (fwd && hit_ctrl) ? hwdata[7:0] : regs.ctrl_value;
	wire [7:0] ratio_now = (fwd && hit_ratio) ? hwdata[7:0] : regs.ratio_value;
	wire [31:0] next_rdata = hit_ctrl ? {24'h000000, ctrl_now} :
	                         hit_ratio ? {24'h000000, ratio_now} : 32'h00000000;

	assign regs.wr_ctrl  = wr_pending & (wr_addr == `PCO_CTRL_ADDR);
	assign regs.wr_ratio = wr_pending & (wr_addr == `PCO_RATIO_ADDR);
	assign regs.wdata    = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr    <= 32'h00000000;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wr_pending <= take & hwrite;
			wr_addr    <= haddr;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			if (take && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end
endmodule

// ==== rtl/pco_top.sv ====
// Purpose: PLL control and clock output pin source selection
// Assumes: XTAL_IN, VCO_IN and timer pulses are synchronous to CORE_CLK
// Notes:   Clock sources are modelled as sampled levels; pin outputs are registered
// Notes on behaviour
// - The first stage halves the VCO, which runs at the crystal frequency times the feedback factor.
// - The PLL output clock is the first stage divided by the output ratio register.
// - Feedback code 00 and 11 give 23, code 01 gives 27, code 10 gives 28.
// - Selector 0h hands the pin to general I/O.
// - Selector 1h puts the PLL output clock on the pin.
// - Selector 2h holds the pin low and 3h holds it high.
// - Selectors 4h to 7h show the crystal clock divided by 1, 2, 4 and 8.
// - Selectors 8h to Bh toggle the pin on each overflow of timer 0 to 3.
// - Control bit 3 enables the clock on the pin; when clear no clock appears.
// - The output ratio divides by its own value for 8 to 254; 0 to 7 are reserved.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pco_consts.svh"
module pco_top (
	input  wire logic        CORE_CLK,
	input  wire logic        RESETN,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        XTAL_IN,
	input  wire logic        VCO_IN,
	input  wire logic [3:0]  TIMER_OVERFLOW,
	input  wire logic        GPIO_DRIVE,
	input  wire logic        GPIO_DRIVE_EN,
	output logic             CLOCK_OUTPUT_PIN_O,
	output logic             CLOCK_OUTPUT_PIN_OE,
	output logic             SYNTH_POWER_DOWN,
	output logic      [4:0]  SYNTH_FEEDBACK_FACTOR
);
	pco_reg_if regs ();

	pco_ahb_slave u_bus (
		.hclk      (CORE_CLK),
		.hresetn   (RESETN),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hwdata    (HWDATA),
		.hready    (HREADY),
		.hrdata    (HRDATA),
		.hreadyout (HREADYOUT),
		.hresp     (HRESP),
		.regs      (regs.bus)
	);

	pco_pkg::pco_byte_type ctrl;
	pco_pkg::pco_byte_type ratio;
	logic                  xtal_q;
	logic [2:0]            xtal_count;
	logic                  vco_q;
	logic                  first_stage;
	logic                  pll_clk;
	logic                  timer_level;

	assign regs.ctrl_value  = ctrl;
	assign regs.ratio_value = ratio;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl  <= `PCO_CTRL_RESET;
			ratio <= `PCO_RATIO_RESET;
		end else begin
			if (regs.wr_ctrl) begin
				ctrl <= regs.wdata;
			end
			if (regs.wr_ratio) begin
				ratio <= regs.wdata;
			end
		end
	end

	pco_pkg::pco_select_type source_select;
	wire drive_enable = ctrl[`PCO_EN_BIT];
	wire power_down   = ctrl[`PCO_PD_BIT];
	wire [1:0] fb_code = ctrl[`PCO_FB_MSB:`PCO_FB_LSB];
	assign source_select = ctrl[`PCO_SEL_MSB:`PCO_SEL_LSB];

	// Feedback factor decode
	wire [4:0] next_feedback = (fb_code == `PCO_FB_CODE_27) ? `PCO_FB_MUL_27 :
	                           (fb_code == `PCO_FB_CODE_28) ? `PCO_FB_MUL_28 :
	                           `PCO_FB_MUL_23;

	// Crystal edges feed a binary counter; bit n is the crystal over 2^(n+1)
	wire xtal_rise = XTAL_IN & ~xtal_q;

	// VCO edges; halving is the first stage
	wire vco_rise   = VCO_IN & ~vco_q;
	wire first_rise = vco_rise & ~first_stage;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			xtal_q      <= 1'b0;
			xtal_count  <= 3'h0;
			vco_q       <= 1'b0;
			first_stage <= 1'b0;
		end else begin
			xtal_q <= XTAL_IN;
			vco_q  <= VCO_IN;
			if (xtal_rise) begin
				xtal_count <= xtal_count + 3'h1;
			end
			if (power_down) begin
				first_stage <= 1'b0;
			end else if (vco_rise) begin
				first_stage <= ~first_stage;
			end
		end
	end

	// Reserved ratios below 8 still count but give no promised frequency
	pco_ratio_div #(
		.WIDTH (8)
	) u_out_div (
		.clk     (CORE_CLK),
		.rst_n   (RESETN),
		.clear   (power_down),
		.tick    (first_rise),
		.ratio   (ratio),
		.div_out (pll_clk)
	);

	// Timer toggle modes
	wire sel_timer = (source_select >= `PCO_SEL_TIMER_FIRST) && (source_select <= `PCO_SEL_TIMER_LAST);
	wire timer_hit = sel_timer & drive_enable & TIMER_OVERFLOW[source_select[1:0]];

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			timer_level <= 1'b0;
		end else if (timer_hit) begin
			timer_level <= ~timer_level;
		end
	end

	// Pin source selection
	wire sel_gpio  = source_select == `PCO_SEL_GPIO;
	wire sel_clock = (source_select == `PCO_SEL_PLL) ||
	                 ((source_select >= `PCO_SEL_XTAL) && (source_select <= `PCO_SEL_TIMER_LAST));
	wire clock_value = (source_select == `PCO_SEL_PLL)       ? (pll_clk & ~power_down) :
	                   (source_select == `PCO_SEL_XTAL)      ? xtal_q :
	                   (source_select == `PCO_SEL_XTAL_DIV2) ? xtal_count[0] :
	                   (source_select == `PCO_SEL_XTAL_DIV4) ? xtal_count[1] :
	                   (source_select == `PCO_SEL_XTAL_DIV8) ? xtal_count[2] :
	                   timer_level;
	// Reserved codes drive low rather than float, keeping the pad defined
	wire next_pin_o  = sel_gpio ? GPIO_DRIVE :
	                   (source_select == `PCO_SEL_LOW)  ? 1'b0 :
	                   (source_select == `PCO_SEL_HIGH) ? 1'b1 :
	                   sel_clock ? (drive_enable & clock_value) :
	                   1'b0;
	wire next_pin_oe = sel_gpio ? GPIO_DRIVE_EN : 1'b1;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			CLOCK_OUTPUT_PIN_O    <= 1'b0;
			CLOCK_OUTPUT_PIN_OE   <= 1'b0;
			SYNTH_POWER_DOWN      <= 1'b1;
			SYNTH_FEEDBACK_FACTOR <= `PCO_FB_MUL_23;
		end else begin
			CLOCK_OUTPUT_PIN_O    <= next_pin_o;
			CLOCK_OUTPUT_PIN_OE   <= next_pin_oe;
			SYNTH_POWER_DOWN      <= power_down;
			SYNTH_FEEDBACK_FACTOR <= next_feedback;
		end
	end
endmodule

// ==== tb/pco_top_chk.sv ====
// Purpose: Port-level checks of the clock output control
// Assumes: Control register shadowed from the bus writes seen at the ports
// Notes:   Pin checks wait until the setting has settled a few cycles
`timescale 1ns/1ps
`include "pco_consts.svh"
module pco_top_chk (
	input wire logic        CORE_CLK,
	input wire logic        RESETN,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic        XTAL_IN,
	input wire logic [3:0]  TIMER_OVERFLOW,
	input wire logic        GPIO_DRIVE,
	input wire logic        GPIO_DRIVE_EN,
	input wire logic        CLOCK_OUTPUT_PIN_O,
	input wire logic        CLOCK_OUTPUT_PIN_OE,
	input wire logic        SYNTH_POWER_DOWN,
	input wire logic [4:0]  SYNTH_FEEDBACK_FACTOR
);
	logic                    pend;
	logic [2:0]              stab;
	pco_pkg::pco_byte_type   ctrl;
	pco_pkg::pco_select_type sel;
	logic [4:0]              fb_exp;
	wire logic               take;
	assign take = pend && HREADY;
	assign sel = ctrl[`PCO_SEL_MSB:`PCO_SEL_LSB];
	assign fb_exp = (ctrl[1:0] == `PCO_FB_CODE_27) ? `PCO_FB_MUL_27 :
		(ctrl[1:0] == `PCO_FB_CODE_28) ? `PCO_FB_MUL_28 : `PCO_FB_MUL_23;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// Shadow kept from the bus so that settle time can be counted here
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pend <= 1'b0;
			ctrl <= `PCO_CTRL_RESET;
			stab <= 3'h0;
		end else begin
			if (HREADY)
				pend <= HSEL && HTRANS[1] && HWRITE && HADDR == `PCO_CTRL_ADDR;
			if (take)
				ctrl <= HWDATA[7:0];
			if (take && HWDATA[7:0] != ctrl)
				stab <= 3'h0;
			else if (stab != 3'h7)
				stab <= stab + 3'h1;
		end
	end
	a_fb_factor: assert property (stab > 3'h1 |->
		SYNTH_FEEDBACK_FACTOR == fb_exp) else $error("feedback factor wrong");
	a_pd_mirror: assert property (stab > 3'h1 |->
		SYNTH_POWER_DOWN == ctrl[`PCO_PD_BIT]) else $error("power down wrong");
	a_gpio_pass: assert property (stab > 3'h1 && sel == `PCO_SEL_GPIO |->
		CLOCK_OUTPUT_PIN_O == $past(GPIO_DRIVE) && CLOCK_OUTPUT_PIN_OE == $past(GPIO_DRIVE_EN))
		else $error("pin not handed to general I/O");
	a_static_low: assert property (stab > 3'h1 && sel == `PCO_SEL_LOW |->
		!CLOCK_OUTPUT_PIN_O && CLOCK_OUTPUT_PIN_OE) else $error("pin not held low");
	a_static_high: assert property (stab > 3'h1 && sel == `PCO_SEL_HIGH |->
		CLOCK_OUTPUT_PIN_O && CLOCK_OUTPUT_PIN_OE) else $error("pin not held high");
	a_disabled_low: assert property (stab > 3'h1 && !ctrl[`PCO_EN_BIT] && sel != `PCO_SEL_GPIO
		&& sel != `PCO_SEL_LOW && sel != `PCO_SEL_HIGH |-> !CLOCK_OUTPUT_PIN_O)
		else $error("clock on pin while disabled");
	a_xtal_follow: assert property (stab > 3'h2 && ctrl[`PCO_EN_BIT] && sel == `PCO_SEL_XTAL |->
		CLOCK_OUTPUT_PIN_O == $past(XTAL_IN, 2)) else $error("crystal not on pin");
	a_timer_toggle: assert property (stab > 3'h2 && ctrl[`PCO_EN_BIT] && sel[3:2] == 2'h2
		&& TIMER_OVERFLOW[sel[1:0]] |=> ##1 CLOCK_OUTPUT_PIN_O != $past(CLOCK_OUTPUT_PIN_O))
		else $error("pin not toggled by overflow");
	a_pll_stopped: assert property (stab == 3'h7 && ctrl[`PCO_PD_BIT] && sel == `PCO_SEL_PLL |->
		!CLOCK_OUTPUT_PIN_O) else $error("clock while PLL down");
endmodule
bind pco_top pco_top_chk chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .XTAL_IN(XTAL_IN),
	.TIMER_OVERFLOW(TIMER_OVERFLOW), .GPIO_DRIVE(GPIO_DRIVE), .GPIO_DRIVE_EN(GPIO_DRIVE_EN),
	.CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O), .CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE),
	.SYNTH_POWER_DOWN(SYNTH_POWER_DOWN), .SYNTH_FEEDBACK_FACTOR(SYNTH_FEEDBACK_FACTOR));

// ==== tb/pll_clock_output_control_test.sv ====
// Purpose: Register and pin tests of the clock output control
// Assumes: Crystal and VCO levels toggle every core cycle
// Notes:   Edge counts allow one edge of slack for phase
`timescale 1ns/1ps
`include "pco_consts.svh"
module pll_clock_output_control_test;
	logic        CORE_CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic        HSEL = 1'b0;
	logic        HWRITE = 1'b0;
	logic        XTAL_IN = 1'b0;
	logic        VCO_IN = 1'b0;
	logic        GPIO_DRIVE = 1'b0;
	logic        GPIO_DRIVE_EN = 1'b0;
	logic [1:0]  HTRANS = 2'h0;
	logic [3:0]  TIMER_OVERFLOW = 4'h0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] rd;
	logic        v;
	wire logic [31:0] HRDATA;
	wire logic        HREADYOUT;
	wire logic        hresp;
	wire logic        O;
	wire logic        OE;
	wire logic        pd;
	wire logic [4:0]  fb;
	logic [4:0]  mul [4] = '{`PCO_FB_MUL_23, `PCO_FB_MUL_27, `PCO_FB_MUL_28, `PCO_FB_MUL_23};
	int          fails = 0;
	int          compares = 0;
	int          i;
	always #20 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		XTAL_IN <= ~XTAL_IN;
		VCO_IN <= ~VCO_IN;
	end
	pco_top dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(hresp), .XTAL_IN(XTAL_IN), .VCO_IN(VCO_IN),
		.TIMER_OVERFLOW(TIMER_OVERFLOW), .GPIO_DRIVE(GPIO_DRIVE), .GPIO_DRIVE_EN(GPIO_DRIVE_EN),
		.CLOCK_OUTPUT_PIN_O(O), .CLOCK_OUTPUT_PIN_OE(OE), .SYNTH_POWER_DOWN(pd),
		.SYNTH_FEEDBACK_FACTOR(fb));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One single-word transfer; read data lands in rd
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'h2;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
		rd = HRDATA;
	endtask
	task idle(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask
	// Rising pin edges over n cycles against e, one edge of slack
	task edges(input int n, input int e);
		int k;
		logic p;
		k = 0;
		p = O;
		repeat (n) begin
			@(posedge CORE_CLK);
			if (O === 1'b1 && p === 1'b0)
				k++;
			p = O;
		end
		check(32'(k >= e - 1 && k <= e + 1), 32'h1);
	endtask
	initial begin
		// Tests take about 3350 cycles; the longest divider window alone is 2032
		idle(6000);
		fails++;
		stop_test;
	end
	initial begin
		idle(4);
		RESETN <= 1'b1;
		idle(1);
		bus(1'b0, `PCO_CTRL_ADDR, 32'h0);
		check(rd, 32'(`PCO_CTRL_RESET));
		bus(1'b0, `PCO_RATIO_ADDR, 32'h0);
		check(rd, 32'(`PCO_RATIO_RESET));
		bus(1'b1, `PCO_RATIO_ADDR, 32'hffffff0a);
		bus(1'b0, `PCO_RATIO_ADDR, 32'h0);
		check(rd, 32'h0a);
		bus(1'b1, 32'hfc, 32'h5a);
		bus(1'b0, 32'hfc, 32'h0);
		check(rd, 32'h0);
		check({31'h0, hresp}, 32'h0);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, `PCO_CTRL_ADDR, 32'h20 | i);
			idle(3);
			check(32'(fb), 32'(mul[i]));
			check(32'(pd), 32'h0);
			bus(1'b1, `PCO_CTRL_ADDR, 32'h20 + (i[0] << 4) + (i[1] << 3));
			idle(3);
			check({30'h0, O, OE}, {30'h0, i[0], 1'b1});
		end
		bus(1'b1, `PCO_CTRL_ADDR, 32'h08);
		GPIO_DRIVE <= 1'b1;
		GPIO_DRIVE_EN <= 1'b1;
		idle(3);
		check({30'h0, O, OE}, 32'h3);
		GPIO_DRIVE_EN <= 1'b0;
		idle(3);
		check({31'h0, OE}, 32'h0);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, `PCO_CTRL_ADDR, 32'h48 + (i << 4));
			idle(4);
			edges(64, 32 >> i);
		end
		bus(1'b1, `PCO_CTRL_ADDR, 32'h40);
		edges(64, 0);
		check({31'h0, O}, 32'h0);
		bus(1'b1, `PCO_CTRL_ADDR, 32'h18);
		for (i = 8; i < 255; i = (i == 8) ? 10 : ((i == 10) ? 254 : 255)) begin
			bus(1'b1, `PCO_RATIO_ADDR, i);
			idle(8);
			edges(i * ((i > 10) ? 8 : 40), (i > 10) ? 2 : 10);
		end
		bus(1'b1, `PCO_CTRL_ADDR, 32'h1c);
		idle(10);
		edges(80, 0);
		check({30'h0, O, pd}, 32'h1);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, `PCO_CTRL_ADDR, 32'h88 + (i << 4));
			idle(4);
			v = O;
			TIMER_OVERFLOW <= 4'h1 << i;
			idle(1);
			TIMER_OVERFLOW <= 4'h1 << ((i + 1) % 4);
			idle(1);
			TIMER_OVERFLOW <= 4'h0;
			idle(3);
			check({31'h0, O}, {31'h0, ~v});
			bus(1'b1, `PCO_CTRL_ADDR, 32'h80 + (i << 4));
			idle(3);
			check({31'h0, O}, 32'h0);
		end
		stop_test;
	end
endmodule
